// >>> rtl/asc_pair_buf.sv
// Purpose: two-entry result buffer with valid/ready on both sides
// Assumes: same clock on both sides
// Notes: full and empty come from an occupancy count
`timescale 1ns/1ps
`default_nettype none

module asc_pair_buf (
   input wire logic clk,
   input wire logic rst,
   asc_stream_if.snk in_s,
   asc_stream_if.src out_s
);
   logic [asc_pkg::RES_W-1:0] mem_r [2];
   logic [asc_pkg::RES_W-1:0] mem_nxt [2];
   logic wr_r, wr_nxt, rd_r, rd_nxt;
   logic [1:0] cnt_r, cnt_nxt;
   logic push, pop;

   assign in_s.ready = (cnt_r != 2'h2);
   assign out_s.valid = (cnt_r != 2'h0);
   assign out_s.data = mem_r[rd_r];
   assign push = in_s.valid && in_s.ready;
   assign pop = out_s.valid && out_s.ready;

   always_comb begin
      mem_nxt = mem_r;
      wr_nxt = wr_r;
      rd_nxt = rd_r;
      cnt_nxt = cnt_r;
      if (push) begin
         mem_nxt[wr_r] = in_s.data;
         wr_nxt = !wr_r;
      end
      if (pop) begin
         rd_nxt = !rd_r;
      end
      if (push && !pop) begin
         cnt_nxt = cnt_r + 2'h1;
      end else if (pop && !push) begin
         cnt_nxt = cnt_r - 2'h1;
      end
   end

   always_ff @(posedge clk) begin
      if (rst) begin
         wr_r <= 1'b0;
         rd_r <= 1'b0;
         cnt_r <= 2'h0;
         mem_r[0] <= 12'h000;
         mem_r[1] <= 12'h000;
      end else begin
         wr_r <= wr_nxt;
         rd_r <= rd_nxt;
         cnt_r <= cnt_nxt;
         mem_r <= mem_nxt;
      end
   end

   buf_count_a: assert property (@(posedge clk) disable iff (rst)
      cnt_r != 2'h3) else $error("buffer count out of range");
   cov_buf_full: cover property (@(posedge clk) disable iff (rst) cnt_r == 2'h2);

endmodule // asc_pair_buf

`default_nettype wire

// >>> rtl/asc_pkg.sv
// Purpose: shared constants and types of the converter serial control block
// Assumes: 200 MHz ref_clk, 12-bit conversion result
// Notes: command word is shifted in most significant bit first

package asc_pkg;

   // ----------------------------------------------------------------
   // command word layout
   // ----------------------------------------------------------------
   localparam int CMD_W = 8;
   localparam int RES_W = 12;
   localparam int OUT_W = 16;
   localparam logic [3:0] PD_ADDR = 4'hE;
   localparam logic [7:0] CMD_RESET = 8'h00;

   // ----------------------------------------------------------------
   // length field codes and bit counts
   // ----------------------------------------------------------------
   localparam logic [1:0] LEN_8 = 2'h1;
   localparam logic [1:0] LEN_16 = 2'h3;
   localparam logic [1:0] LEN_RESET = 2'h0;
   localparam logic [4:0] NBITS_8 = 5'h08;
   localparam logic [4:0] NBITS_12 = 5'h0C;
   localparam logic [4:0] NBITS_16 = 5'h10;

   // ----------------------------------------------------------------
   // shift-clock edge counts
   // ----------------------------------------------------------------
   localparam logic [4:0] CMD_RISES = 5'h08;
   localparam logic [4:0] LEN_LATCH_RISE = 5'h06;
   localparam logic [4:0] SAMPLE_FALL = 5'h04;

   // ----------------------------------------------------------------
   // conversion timing and reset values
   // ----------------------------------------------------------------
   localparam int CLK_PERIOD_NS = 5;
   localparam int CONV_STEP_NS = 40;
   localparam logic [5:0] STEP_CYC = 6'((CONV_STEP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
   localparam logic [11:0] SAR_START = 12'h800;
   localparam logic [3:0] SAR_TOP = 4'hB;
   localparam logic EOC_RESET = 1'b1;
   localparam logic PD_RESET = 1'b1;

   typedef enum logic [1:0] {S_IO, S_CONV, S_LOAD} asc_state_e;

endpackage

// >>> rtl/asc_serial_ctrl.sv
// Purpose: serial command capture, conversion sequencing and result formatting
// Assumes: cs_n, io_clk and data_in arrive asynchronously from the host
// Notes: io_clk is sampled by ref_clk; its edges are found after synchronisation
`timescale 1ns/1ps
`default_nettype none

module asc_serial_ctrl (
   input wire logic ref_clk,
   input wire logic rst,
   input wire logic cs_n,
   input wire logic io_clk,
   input wire logic data_in,
   input wire logic cmp_hi,
   output logic data_out,
   output logic data_out_oe,
   output logic eoc,
   output logic [3:0] channel_sel,
   output logic sample_en,
   output logic power_down,
   output logic [11:0] sar_trial
);
   // ----------------------------------------------------------------
   // input synchronisers
   // ----------------------------------------------------------------
   logic cs_s1, cs_s2, cs_d;
   logic ck_s1, ck_s2, ck_d;
   logic di_s1, di_s2;
   logic ck_rise, ck_fall, cs_fall;

   always_ff @(posedge ref_clk) begin
      if (rst) begin
         cs_s1 <= 1'b1;
         cs_s2 <= 1'b1;
         cs_d <= 1'b1;
         ck_s1 <= 1'b0;
         ck_s2 <= 1'b0;
         ck_d <= 1'b0;
         di_s1 <= 1'b0;
         di_s2 <= 1'b0;
      end else begin
         cs_s1 <= cs_n;
         cs_s2 <= cs_s1;
         cs_d <= cs_s2;
         ck_s1 <= io_clk;
         ck_s2 <= ck_s1;
         ck_d <= ck_s2;
         di_s1 <= data_in;
         di_s2 <= di_s1;
      end
   end

   assign ck_rise = ck_s2 && !ck_d;
   assign ck_fall = !ck_s2 && ck_d;
   assign cs_fall = !cs_s2 && cs_d;

   // ----------------------------------------------------------------
   // helpers
   // ----------------------------------------------------------------
   function automatic logic [4:0] len_bits(input logic [1:0] len);
      unique case (len)
         asc_pkg::LEN_8: return asc_pkg::NBITS_8;
         asc_pkg::LEN_16: return asc_pkg::NBITS_16;
         default: return asc_pkg::NBITS_12;
      endcase
   endfunction

   // result left justified; lsb order reverses only the bits actually sent
   function automatic logic [15:0] fmt_out(input logic [11:0] res, input logic [1:0] len,
                                           input logic reverse_order_flag);
      logic [15:0] w;
      logic [15:0] r;
      w = {res, 4'h0};
      for (int i = 0; i < asc_pkg::OUT_W; i++) begin
         r[i] = w[asc_pkg::OUT_W-1-i];
      end
      if (!reverse_order_flag) begin
         return w;
      end
      unique case (len)
         asc_pkg::LEN_8: return r << 8;
         asc_pkg::LEN_16: return r;
         default: return r << 4;
      endcase
   endfunction

   // ----------------------------------------------------------------
   // control state
   // ----------------------------------------------------------------
   asc_pkg::asc_state_e st_r, st_nxt;
   logic [7:0] cmd_sr_r, cmd_sr_nxt;
   logic [4:0] rise_cnt_r, rise_cnt_nxt, fall_cnt_r, fall_cnt_nxt;
   logic [1:0] len_r, len_nxt;
   logic order_r, order_nxt, coding_r, coding_nxt;
   logic [15:0] out_sr_r, out_sr_nxt, load_w;
   logic [11:0] res_r, res_nxt, code_r, code_nxt, code_w;
   logic [3:0] idx_r, idx_nxt, chan_r, chan_nxt;
   logic [5:0] step_r, step_nxt;
   logic push_v_r, push_v_nxt;
   logic [11:0] push_d_r, push_d_nxt;
   logic dout_r, dout_nxt, oe_r, eoc_r, eoc_nxt, pd_r, pd_nxt, smp_r, smp_nxt;
   logic cyc_end;

   asc_stream_if buf_i ();
   asc_stream_if buf_o ();

   asc_pair_buf u_buf (
      .clk(ref_clk),
      .rst(rst),
      .in_s(buf_i),
      .out_s(buf_o)
   );

   // no push in the cs fall cycle: a word landing then would be loaded as the next result
   assign buf_i.valid = push_v_r && !cs_fall;
   assign buf_i.data = push_d_r;
   // cs fall drains a result left over from an aborted sequence
   assign buf_o.ready = (st_r == asc_pkg::S_LOAD) || cs_fall;
   assign cyc_end = ck_fall && !cs_s2 && (st_r == asc_pkg::S_IO)
                    && (fall_cnt_r + 5'h01 == len_bits(len_r));
   assign load_w = fmt_out(buf_o.data, len_r, order_r);

   always_comb begin
      st_nxt = st_r;
      cmd_sr_nxt = cmd_sr_r;
      rise_cnt_nxt = rise_cnt_r;
      fall_cnt_nxt = fall_cnt_r;
      len_nxt = len_r;
      order_nxt = order_r;
      coding_nxt = coding_r;
      out_sr_nxt = out_sr_r;
      res_nxt = res_r;
      code_nxt = code_r;
      idx_nxt = idx_r;
      chan_nxt = chan_r;
      step_nxt = step_r;
      push_v_nxt = push_v_r;
      push_d_nxt = push_d_r;
      dout_nxt = dout_r;
      eoc_nxt = eoc_r;
      pd_nxt = pd_r;
      smp_nxt = smp_r;
      code_w = code_r;
      if (cs_fall) begin
         // interface reset; any running conversion is abandoned
         st_nxt = asc_pkg::S_IO;
         cmd_sr_nxt = asc_pkg::CMD_RESET;
         rise_cnt_nxt = 5'h00;
         fall_cnt_nxt = 5'h00;
         eoc_nxt = 1'b1;
         smp_nxt = 1'b0;
         push_v_nxt = 1'b0;
         out_sr_nxt = fmt_out(res_r, len_r, order_r);
         dout_nxt = out_sr_nxt[15];
      end else begin
         unique case (st_r)
            asc_pkg::S_IO: begin
               if (!cs_s2 && ck_rise && rise_cnt_r < asc_pkg::CMD_RISES) begin
                  cmd_sr_nxt = {cmd_sr_r[6:0], di_s2};
                  rise_cnt_nxt = rise_cnt_r + 5'h01;
                  if (rise_cnt_r == asc_pkg::LEN_LATCH_RISE - 5'h01) begin
                     len_nxt = {cmd_sr_r[0], di_s2};
                  end
               end
               if (!cs_s2 && ck_fall) begin
                  fall_cnt_nxt = fall_cnt_r + 5'h01;
                  out_sr_nxt = out_sr_r << 1;
                  dout_nxt = out_sr_r[14];
                  if (fall_cnt_nxt == asc_pkg::SAMPLE_FALL) begin
                     pd_nxt = (cmd_sr_r[3:0] == asc_pkg::PD_ADDR);
                     smp_nxt = !pd_nxt;
                  end
                  if (cyc_end) begin
                     chan_nxt = cmd_sr_r[7:4];
                     order_nxt = cmd_sr_r[1];
                     coding_nxt = cmd_sr_r[0];
                     smp_nxt = 1'b0;
                     rise_cnt_nxt = 5'h00;
                     fall_cnt_nxt = 5'h00;
                     if (pd_nxt) begin
                        // powered down: no conversion, old result offered again
                        out_sr_nxt = fmt_out(res_r, len_r, cmd_sr_r[1]);
                        dout_nxt = out_sr_nxt[15];
                     end else begin
                        st_nxt = asc_pkg::S_CONV;
                        eoc_nxt = 1'b0;
                        dout_nxt = 1'b0;
                        code_nxt = asc_pkg::SAR_START;
                        idx_nxt = asc_pkg::SAR_TOP;
                        step_nxt = 6'h00;
                     end
                  end
               end
            end
            asc_pkg::S_CONV: begin
               if (step_r == asc_pkg::STEP_CYC - 6'h01) begin
                  step_nxt = 6'h00;
                  code_w[idx_r] = cmp_hi;
                  code_nxt = code_w;
                  if (idx_r == 4'h0) begin
                     push_v_nxt = 1'b1;
                     push_d_nxt = code_w ^ {coding_r, 11'h000};
                     st_nxt = asc_pkg::S_LOAD;
                  end else begin
                     code_nxt[idx_r - 4'h1] = 1'b1;
                     idx_nxt = idx_r - 4'h1;
                  end
               end else begin
                  step_nxt = step_r + 6'h01;
               end
            end
            asc_pkg::S_LOAD: begin
               if (push_v_r && buf_i.ready) begin
                  push_v_nxt = 1'b0;
               end
               if (buf_o.valid) begin
                  res_nxt = buf_o.data;
                  out_sr_nxt = load_w;
                  dout_nxt = load_w[15];
                  eoc_nxt = 1'b1;
                  cmd_sr_nxt = asc_pkg::CMD_RESET;
                  st_nxt = asc_pkg::S_IO;
               end
            end
         endcase
      end
   end

   always_ff @(posedge ref_clk) begin
      if (rst) begin
         st_r <= asc_pkg::S_IO;
         cmd_sr_r <= asc_pkg::CMD_RESET;
         rise_cnt_r <= 5'h00;
         fall_cnt_r <= 5'h00;
         len_r <= asc_pkg::LEN_RESET;
         order_r <= 1'b0;
         coding_r <= 1'b0;
         out_sr_r <= 16'h0000;
         res_r <= 12'h000;
         code_r <= 12'h000;
         idx_r <= 4'h0;
         chan_r <= 4'h0;
         step_r <= 6'h00;
         push_v_r <= 1'b0;
         push_d_r <= 12'h000;
         dout_r <= 1'b0;
         oe_r <= 1'b0;
         eoc_r <= asc_pkg::EOC_RESET;
         pd_r <= asc_pkg::PD_RESET;
         smp_r <= 1'b0;
      end else begin
         st_r <= st_nxt;
         cmd_sr_r <= cmd_sr_nxt;
         rise_cnt_r <= rise_cnt_nxt;
         fall_cnt_r <= fall_cnt_nxt;
         len_r <= len_nxt;
         order_r <= order_nxt;
         coding_r <= coding_nxt;
         out_sr_r <= out_sr_nxt;
         res_r <= res_nxt;
         code_r <= code_nxt;
         idx_r <= idx_nxt;
         chan_r <= chan_nxt;
         step_r <= step_nxt;
         push_v_r <= push_v_nxt;
         push_d_r <= push_d_nxt;
         dout_r <= dout_nxt;
         oe_r <= !cs_s2;
         eoc_r <= eoc_nxt;
         pd_r <= pd_nxt;
         smp_r <= smp_nxt;
      end
   end

   assign data_out = dout_r;
   assign data_out_oe = oe_r;
   assign eoc = eoc_r;
   assign channel_sel = chan_r;
   assign sample_en = smp_r;
   assign power_down = pd_r;
   assign sar_trial = code_r;

   // ----------------------------------------------------------------
   // checks
   // ----------------------------------------------------------------
   default clocking cb @(posedge ref_clk); endclocking
   default disable iff (rst);

   oe_release_a: assert property (cs_s2 |=> !data_out_oe)
      else $error("output enabled with chip select high");
   conv_zero_a: assert property (!eoc_r |-> !dout_r)
      else $error("serial output not zero during conversion");
   eoc_fall_a: assert property (cyc_end && !pd_nxt && !cs_fall |=> !eoc_r ##1 !eoc_r)
      else $error("conversion did not start after last falling edge");
   pd_hold_a: assert property (cyc_end && pd_nxt && !cs_fall |=> eoc_r && st_r == asc_pkg::S_IO)
      else $error("conversion ran in power-down");
   len_take_a: assert property (ck_rise && !cs_s2 && !cs_fall && st_r == asc_pkg::S_IO && rise_cnt_r == 5'h05
      |=> len_r[1] == $past(cmd_sr_r[0]) && len_r[0] == $past(di_s2))
      else $error("length not taken on sixth rising edge");
   cmd_ignore_a: assert property (rise_cnt_r == asc_pkg::CMD_RISES && !cs_fall
      && st_r == asc_pkg::S_IO |=> cmd_sr_r == $past(cmd_sr_r))
      else $error("command changed after eighth bit");
   bip_msb_a: assert property (st_r == asc_pkg::S_CONV ##1 st_r == asc_pkg::S_LOAD
      |-> push_d_r[11] == (code_r[11] ^ coding_r))
      else $error("coding msb wrong");
   first_bit_a: assert property ($rose(eoc_r) |-> dout_r == out_sr_r[15])
      else $error("first bit missing at end of conversion");
   bit_step_a: assert property (ck_fall && !cs_s2 && !cs_fall && st_r == asc_pkg::S_IO && !cyc_end
      |=> dout_r == $past(out_sr_r[14]))
      else $error("serial output did not advance");
   cycle_len_a: assert property ($fell(eoc_r) |-> $past(fall_cnt_r) + 5'h01 == len_bits(len_r))
      else $error("conversion started on wrong edge count");
   conv_time_a: assert property ($fell(eoc_r) |-> ##[1:120] (eoc_r || st_r == asc_pkg::S_LOAD))
      else $error("conversion took too long");
   sample_go_a: assert property (ck_fall && !cs_s2 && !cs_fall && st_r == asc_pkg::S_IO
      && fall_cnt_r == 5'h03 && cmd_sr_r[3:0] != asc_pkg::PD_ADDR |=> sample_en)
      else $error("sampling did not start on fourth falling edge");

   cov_conv: cover property ($rose(eoc_r));
   cov_pd: cover property ($rose(pd_r));
   cov_lsb16: cover property ($rose(eoc_r) && order_r && len_r == asc_pkg::LEN_16);
   cov_abort: cover property (cs_fall && st_r == asc_pkg::S_CONV);

endmodule // asc_serial_ctrl

`default_nettype wire

// >>> rtl/asc_stream_if.sv
// Purpose: valid/ready word path between conversion engine and result buffer
// Assumes: single clock domain
// Notes: src drives data, snk drives ready
`timescale 1ns/1ps
`default_nettype none

interface asc_stream_if;
   logic valid;
   logic ready;
   logic [asc_pkg::RES_W-1:0] data;
   modport src (output valid, output data, input ready);
   modport snk (input valid, input data, output ready);
endinterface

`default_nettype wire

// >>> sim/asc_host_model.sv
// Purpose: host serial port model driving the converter control block
// Assumes: 48 ns shift clock, idle low between frames
// Notes: the result word reads data_out only while data_out_oe is high; the conversion check reads data_out directly
`timescale 1ns/1ps
`default_nettype none

module asc_host_model (
   input wire logic ref_clk,
   output logic cs_n,
   output logic io_clk,
   output logic data_in,
   input wire logic data_out,
   input wire logic data_out_oe,
   input wire logic eoc,
   input wire logic sample_en
);
   logic wire_lvl;

   // released line has no pull: read it as floating so a missing enable shows
   assign wire_lvl = data_out_oe ? data_out : 1'bz;

   initial begin
      cs_n = 1'b1;
      io_clk = 1'b0;
      data_in = 1'b0;
   end

   task automatic set_cs(input logic v);
      @(posedge ref_clk);
      #1 cs_n = v;
      repeat (10) @(posedge ref_clk);
   endtask

   // one frame; command goes out msb first, then data_in stays put
   task automatic xfer(input logic [7:0] cmd, input int n, output logic [15:0] word, output logic se_mid,
                       output logic eoc_last, output logic fell, output logic zero_ok);
      word = 16'h0000;
      zero_ok = 1'b1;
      fell = 1'b0;
      @(posedge ref_clk);
      #1;
      for (int i = 0; i < n; i++) begin
         if (i < 8) data_in = cmd[7-i];
         #24 io_clk = 1'b1;
         #20 word = {word[14:0], wire_lvl};
         if (i == 4) se_mid = sample_en;
         eoc_last = eoc;
         #4 io_clk = 1'b0;
      end
      for (int k = 0; k < 10 && !fell; k++) begin
         if (eoc === 1'b0) fell = 1'b1;
         @(posedge ref_clk);
         #1;
      end
      for (int k = 0; k < 400 && fell && eoc !== 1'b1; k++) begin
         if (data_out !== 1'b0) zero_ok = 1'b0;
         @(posedge ref_clk);
         #1;
      end
   endtask
endmodule // asc_host_model

`default_nettype wire

// >>> sim/asc_serial_ctrl_tb_top.sv
// Purpose: self-checking bench for the converter serial control block
// Assumes: 200 MHz ref_clk, host model frames at 48 ns
// Notes: comparator follows a fixed target code, so each result is known
`timescale 1ns/1ps
`default_nettype none

module asc_serial_ctrl_tb_top;
   logic ref_clk = 1'b0;
   logic rst = 1'b1;
   logic cs_n, io_clk, data_in, data_out, data_out_oe, eoc, sample_en, power_down, cmp_hi;
   logic [3:0] channel_sel;
   logic [11:0] sar_trial;
   logic [11:0] target = 12'h000;
   logic [11:0] res = 12'h000;
   logic ord = 1'b0;
   logic valid = 1'b0;
   int mismatches = 0;
   int checks_done = 0;

   always #2.5 ref_clk = ~ref_clk;

   // keep the trial bit while the target sits at or above it
   assign cmp_hi = (sar_trial <= target);

   asc_serial_ctrl dut (
      .ref_clk(ref_clk), .rst(rst), .cs_n(cs_n), .io_clk(io_clk), .data_in(data_in), .cmp_hi(cmp_hi),
      .data_out(data_out), .data_out_oe(data_out_oe), .eoc(eoc), .channel_sel(channel_sel),
      .sample_en(sample_en), .power_down(power_down), .sar_trial(sar_trial)
   );

   asc_host_model host (
      .ref_clk(ref_clk), .cs_n(cs_n), .io_clk(io_clk), .data_in(data_in), .data_out(data_out),
      .data_out_oe(data_out_oe), .eoc(eoc), .sample_en(sample_en)
   );

   task automatic check(input logic [15:0] got, input logic [15:0] exp, input string msg);
      checks_done++;
      if (got !== exp) begin
         mismatches++;
         $display("wrong value at %0t: %s got %h expected %h", $time, msg, got, exp);
      end
   endtask

   task automatic print_verdict();
      $display("checks %0d mismatches %0d", checks_done, mismatches);
      if (mismatches == 0 && checks_done > 0) $display("RESULT: PASS");
      else $display("RESULT: FAIL");
      $finish;
   endtask

   // word as the host shifts it in: first bit lands at position n-1
   function automatic logic [15:0] fmt(input logic [11:0] r, input int n, input logic lsb);
      logic [15:0] w;
      logic [15:0] o;
      w = {r, 4'h0} >> (16 - n);
      o = 16'h0000;
      for (int i = 0; i < n; i++) o[i] = lsb ? w[n-1-i] : w[i];
      return o;
   endfunction

   task automatic run(input logic [7:0] cmd, input logic [11:0] tgt);
      int n;
      logic [15:0] word;
      logic se_mid, eoc_last, fell, zero_ok, pd;
      n = (cmd[3:2] == 2'b01) ? 8 : (cmd[3:2] == 2'b11) ? 16 : 12;
      pd = (cmd[7:4] == asc_pkg::PD_ADDR);
      target = tgt;
      host.xfer(cmd, n, word, se_mid, eoc_last, fell, zero_ok);
      if (valid) check(word, fmt(res, n, ord), "result word");
      check(eoc_last, 1'b1, "eoc before last edge");
      check(fell, !pd, "conversion start");
      check(se_mid, !pd, "sampling window");
      check(zero_ok, 1'b1, "output while converting");
      check(eoc, 1'b1, "eoc after conversion");
      check(channel_sel, cmd[7:4], "address");
      check(power_down, pd, "power down");
      if (!pd) check(sar_trial, tgt, "final trial code");
      // power-down keeps the old result but takes the new order
      if (!pd) res = tgt ^ (cmd[0] ? 12'h800 : 12'h000);
      ord = cmd[1];
      valid = 1'b1;
      $display("test cmd %h done", cmd);
   endtask

   // ----------------------------------------------------------------
   // main sequence
   // ----------------------------------------------------------------
   initial begin
      repeat (12) @(posedge ref_clk);
      #1 rst = 1'b0;
      check(eoc, 1'b1, "eoc at reset");
      check(power_down, 1'b1, "power down at reset");
      check(data_out_oe, 1'b0, "output off at reset");
      repeat (4) @(posedge ref_clk);
      host.set_cs(1'b0);
      run(8'h30, 12'hA5C);
      run(8'h59, 12'h3C1);
      run(8'hAE, 12'h0F0);
      run(8'h1C, 12'h7E5);
      run(8'h25, 12'h123);
      run(8'hE6, 12'hFFF);
      run(8'h44, 12'h800);
      host.set_cs(1'b1);
      check(data_out_oe, 1'b0, "output released");
      host.set_cs(1'b0);
      check(data_out_oe, 1'b1, "output driven");
      run(8'hB0, 12'h5A5);
      run(8'h7A, 12'h000);
      print_verdict();
   end

   // ----------------------------------------------------------------
   // watchdog
   // ----------------------------------------------------------------
   initial begin
      #200us;
      mismatches++;
      $display("wrong value at %0t: watchdog expired", $time);
      print_verdict();
   end
endmodule // asc_serial_ctrl_tb_top

`default_nettype wire
